// [hw/ppd_pkg.sv]
/*
 package for the phase detector and dual modulus divider core: constants and carrier structs.
 assumes one clock, ref_clk, at 250 MHz; all pin inputs are synchronous to it.
*/
package ppd_pkg;
	localparam int unsigned REF_DIV       = 4;
	localparam int unsigned REF_CNT_W     = 2;
	localparam int unsigned PRE_MOD_HIGH  = 16;
	localparam int unsigned PRE_MOD_LOW   = 15;
	localparam int unsigned PRE_CNT_W     = 4;
	localparam logic [3:0]  PRE_LAST_HIGH = 4'hf;
	localparam logic [3:0]  PRE_LAST_LOW  = 4'he;
	localparam logic [3:0]  PRE_HALF      = 4'h8;
	localparam logic [1:0]  REF_HALF      = 2'h2;
	localparam logic [1:0]  REF_CNT_RST   = 2'h0;
	localparam logic [3:0]  PRE_CNT_RST   = 4'h0;

	// comparator inputs and last-seen levels
	typedef struct packed {
		logic in_a;
		logic in_b;
	} ppd_cmp_in_t;

	// comparator pump outputs
	typedef struct packed {
		logic sink_n;
		logic rise;
	} ppd_cmp_out_t;
endpackage

// [hw/ppd_prescaler.sv]
/*
 divide by 16 or 15 prescaler, counting on an enable pulse.
 assumes pre_clk_fall is a one-cycle pulse per falling edge of the prescaler clock pin.
*/
`timescale 1ns/1ps
module ppd_prescaler (
	input  wire logic ref_clk,
	input  wire logic resetn,
	input  wire logic pre_clk_fall,
	input  wire logic modulus_high,
	output logic      pre_out
);
	logic [3:0] count;
	logic [3:0] next_count;
	logic       next_pre_out;
	logic [3:0] last;

	// next count and output level
	always_comb begin
		last = modulus_high ? ppd_pkg::PRE_LAST_HIGH : ppd_pkg::PRE_LAST_LOW;
		next_count = count;
		next_pre_out = pre_out;
		if (pre_clk_fall) begin
			if (count >= last) begin
				next_count = ppd_pkg::PRE_CNT_RST;
			end else begin
				next_count = 4'(count + 4'h1);
			end
			// high for first half, one fall per cycle
			next_pre_out = (next_count < ppd_pkg::PRE_HALF);
		end
	end

	// register the state
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			count   <= ppd_pkg::PRE_CNT_RST;
			pre_out <= 1'b1;
		end else begin
			count   <= next_count;
			pre_out <= next_pre_out;
		end
	end
endmodule

// [hw/ppd_top.sv]
/*
 pll digital core: reference divide by four, phase/frequency comparator, dual modulus prescaler.
 assumes all inputs synchronous to ref_clk; the external counter drives modulus_high.
*/
// How it works
// - reference clock divided by four in fixed stage, shown on ref_div4_out.
// - comparator reacts only to falling edges of each input.
// - pump pulse lasts from first input fall to second input fall.
// - edge-latched state machine detects frequency and phase, locks at zero phase.
// - a falls first: sink_n pulses low, rise stays low.
// - b falls first: rise pulses high, sink_n stays high.
// - prescaler divides by 16 when modulus_high is high, else 15.
`timescale 1ns/1ps
module ppd_top (
	input  wire logic ref_clk,
	input  wire logic resetn,
	input  wire logic osc_in,
	output logic      ref_div4_out,
	input  wire logic cmp_a,
	input  wire logic cmp_b,
	output logic      sink_n,
	output logic      rise,
	input  wire logic pre_clk,
	input  wire logic modulus_high,
	output logic      pre_out
);
	typedef enum logic [2:0] {
		PPD_IDLE = 3'b001,
		PPD_DOWN = 3'b010,
		PPD_UP   = 3'b100
	} ppd_state_t;

	ppd_pkg::ppd_cmp_in_t  cmp_prev;
	ppd_pkg::ppd_cmp_in_t  next_cmp_prev;
	ppd_pkg::ppd_cmp_out_t cmp_q;
	ppd_pkg::ppd_cmp_out_t next_cmp_q;
	ppd_state_t            state;
	ppd_state_t            next_state;
	logic                  fall_a;
	logic                  fall_b;
	logic                  osc_prev;
	logic                  next_osc_prev;
	logic [1:0]            ref_cnt;
	logic [1:0]            next_ref_cnt;
	logic                  next_ref_div4;
	logic                  pre_prev;
	logic                  next_pre_prev;
	logic                  pre_clk_fall;

	// reference divider: counts oscillator rising edges
	always_comb begin
		next_osc_prev = osc_in;
		next_ref_cnt  = ref_cnt;
		if (osc_in && !osc_prev) begin
			next_ref_cnt = 2'(ref_cnt + 2'h1);
		end
		next_ref_div4 = (next_ref_cnt < ppd_pkg::REF_HALF);
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			osc_prev     <= 1'b0;
			ref_cnt      <= ppd_pkg::REF_CNT_RST;
			ref_div4_out <= 1'b1;
		end else begin
			osc_prev     <= next_osc_prev;
			ref_cnt      <= next_ref_cnt;
			ref_div4_out <= next_ref_div4;
		end
	end

	// falling edge detect, rising edges ignored
	assign fall_a = cmp_prev.in_a && !cmp_a;
	assign fall_b = cmp_prev.in_b && !cmp_b;

	// comparator state machine
	always_comb begin
		next_cmp_prev.in_a = cmp_a;
		next_cmp_prev.in_b = cmp_b;
		next_state = state;
		unique case (state)
			PPD_IDLE: begin
				// simultaneous falls: zero phase, stay idle
				if (fall_a && !fall_b) begin
					next_state = PPD_DOWN;
				end else if (fall_b && !fall_a) begin
					next_state = PPD_UP;
				end
			end
			PPD_DOWN: begin
				// further a falls keep pulse: frequency detect
				if (fall_b) begin
					next_state = PPD_IDLE;
				end
			end
			PPD_UP: begin
				if (fall_a) begin
					next_state = PPD_IDLE;
				end
			end
			default: begin
				next_state = PPD_IDLE;
			end
		endcase
		// pulse width equals interval between falls
		next_cmp_q.sink_n = (next_state != PPD_DOWN);
		next_cmp_q.rise   = (next_state == PPD_UP);
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cmp_prev <= '0;
			state    <= PPD_IDLE;
			cmp_q    <= '{sink_n: 1'b1, rise: 1'b0};
		end else begin
			cmp_prev <= next_cmp_prev;
			state    <= next_state;
			cmp_q    <= next_cmp_q;
		end
	end

	assign sink_n = cmp_q.sink_n;
	assign rise   = cmp_q.rise;

	// prescaler clock falling edge pulse
	always_comb begin
		next_pre_prev = pre_clk;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pre_prev <= 1'b0;
		end else begin
			pre_prev <= next_pre_prev;
		end
	end

	assign pre_clk_fall = pre_prev && !pre_clk;

	// modulus held high by outside for fixed 16
	ppd_prescaler u_pre (
		.ref_clk      (ref_clk),
		.resetn       (resetn),
		.pre_clk_fall (pre_clk_fall),
		.modulus_high (modulus_high),
		.pre_out      (pre_out)
	);
endmodule

// [testbench/ppd_top_props.sv]
/* pin checker for ppd_top, bound to every ppd_top instance;
 assumes the comparator and prescaler clock pins are sampled on ref_clk like the design does */
`timescale 1ns/1ps
module ppd_top_props (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic cmp_a,
	input wire logic cmp_b,
	input wire logic sink_n,
	input wire logic rise,
	input wire logic pre_clk,
	input wire logic pre_out
);
	logic [4:0] cnt;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// clock falls per output cycle; starts at 8 for the half cycle after reset
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			cnt <= 5'h08;
		else if ($fell(pre_out))
			cnt <= {4'h0, $fell(pre_clk)};
		else if ($fell(pre_clk))
			cnt <= cnt + 5'h01;
	end
	a_sink_on: assert property ($fell(cmp_a) && cmp_b && sink_n && !rise |=> !sink_n && !rise)
		else $error("sink");
	a_rise_on: assert property ($fell(cmp_b) && cmp_a && sink_n && !rise |=> rise && sink_n)
		else $error("rise");
	a_sink_end: assert property (!sink_n && $fell(cmp_b) |=> sink_n) else $error("sink end");
	a_rise_end: assert property (rise && $fell(cmp_a) |=> !rise) else $error("rise end");
	a_idle_kept: assert property (sink_n && !rise && !$fell(cmp_a) && !$fell(cmp_b) |=> sink_n && !rise)
		else $error("idle");
	a_sink_held: assert property (!sink_n && !$fell(cmp_b) |=> !sink_n) else $error("sink held");
	a_rise_held: assert property (rise && !$fell(cmp_a) |=> rise) else $error("rise held");
	a_pre_cycle: assert property ($fell(pre_out) |-> cnt == 5'h0f || cnt == 5'h10)
		else $error("pre cycle");
endmodule
bind ppd_top ppd_top_props u_ppd_top_props (.ref_clk(ref_clk), .resetn(resetn), .cmp_a(cmp_a), .cmp_b(cmp_b),
	.sink_n(sink_n), .rise(rise), .pre_clk(pre_clk), .pre_out(pre_out));

// [testbench/ppd_cnt_model.sv]
/* external counter model driving the modulus; clocked by ref_clk */
`timescale 1ns/1ps
module ppd_cnt_model (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic pre_out,
	input wire logic fixed,
	output logic     modulus_high
);
	logic       prev;
	logic [1:0] c;
	// advance on each output fall, in divide by 16 and divide by 15 cycles alike
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			prev <= 1'b1;
			c <= 2'h0;
		end else begin
			prev <= pre_out;
			if (prev && !pre_out) c <= c + 2'h1;
		end
	end
	// one cycle in four divides by 15
	assign modulus_high = fixed | (c != 2'h3);
endmodule

// [testbench/ppd_top_tb_top.sv]
/* bench for ppd_top with counter model; assumes a 250 MHz ref_clk */
`timescale 1ns/1ps
module ppd_top_tb_top;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic osc_in = 1'b0;
	logic cmp_a = 1'b1;
	logic cmp_b = 1'b1;
	logic pre_clk = 1'b1;
	logic fixed = 1'b1;
	logic ref_div4_out, sink_n, rise, modulus_high, pre_out;
	int   error_cnt = 0;
	int   checked = 0;
	int   cyc = 0;
	always #2 ref_clk = ~ref_clk;
	ppd_top u_ppd_top (.ref_clk(ref_clk), .resetn(resetn), .osc_in(osc_in), .ref_div4_out(ref_div4_out),
		.cmp_a(cmp_a), .cmp_b(cmp_b), .sink_n(sink_n), .rise(rise), .pre_clk(pre_clk),
		.modulus_high(modulus_high), .pre_out(pre_out));
	ppd_cnt_model u_ppd_cnt_model (.ref_clk(ref_clk), .resetn(resetn), .pre_out(pre_out), .fixed(fixed),
		.modulus_high(modulus_high));
	task automatic chk(input string w, input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", w, e, s);
		end
	endtask
	task automatic give_verdict();
		if (error_cnt == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic do_reset();
		@(posedge ref_clk);
		resetn <= 1'b0;
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
	endtask
	task automatic step(input logic a, input logic b);
		@(posedge ref_clk);
		cmp_a <= a;
		cmp_b <= b;
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic t_refdiv();
		logic [7:0] n;
		logic p;
		n = 8'h00;
		p = ref_div4_out;
		repeat (16) begin
			@(posedge ref_clk);
			osc_in <= ~osc_in;
			repeat (3) @(posedge ref_clk);
			if (ref_div4_out !== p) n++;
			p = ref_div4_out;
		end
		chk("div4 edges", n, 8'h04);
		chk("div4 level", 8'(ref_div4_out), 8'h01);
	endtask
	// second pass is a repeated lead fall, as with a frequency offset
	task automatic t_cmp(input logic al);
		repeat (2) begin
			step(!al, al);
			chk("pump", 8'({sink_n, rise}), 8'({2{!al}}));
			step(1'b1, 1'b1);
			chk("pump held", 8'({sink_n, rise}), 8'({2{!al}}));
		end
		step(al, !al);
		chk("pump idle", 8'({sink_n, rise}), 8'h02);
		step(1'b1, 1'b1);
	endtask
	task automatic t_pre(input logic fx, input logic [7:0] el);
		logic [7:0] n, last;
		logic p;
		do_reset();
		fixed <= fx;
		n = 8'h00;
		last = 8'h00;
		p = 1'b1;
		for (int i = 1; i <= 56; i++) begin
			@(posedge ref_clk);
			pre_clk <= 1'b0;
			repeat (3) @(posedge ref_clk);
			if (p && !pre_out) begin
				n++;
				last = i[7:0];
			end
			p = pre_out;
			pre_clk <= 1'b1;
		end
		chk("pre falls", n, 8'h04);
		chk("pre last", last, el);
	endtask
	initial begin
		do_reset();
		t_refdiv();
		t_cmp(1'b1);
		t_cmp(1'b0);
		t_pre(1'b1, 8'h38);
		t_pre(1'b0, 8'h37);
		give_verdict();
	end
	// hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			give_verdict();
		end
	end
endmodule
